/* File: hw/fad_pkg.sv */
// Purpose: shared constants and types of the flag alu datapath
// Assumes: 32-bit register bus, one aligned word per register
// Notes: command word fields are packed from bit 0 upward
package fad_pkg;
  // ****************************************
  // register byte offsets
  // ****************************************
  localparam logic [7:0] OFF_OPA = 8'h00;
  localparam logic [7:0] OFF_OPB = 8'h04;
  localparam logic [7:0] OFF_CMD = 8'h08;
  localparam logic [7:0] OFF_RESULT = 8'h0c;
  localparam logic [7:0] OFF_PSW = 8'h10;
  localparam logic [7:0] OFF_INDEX = 8'h14;
  localparam logic [7:0] OFF_COUNT = 8'h18;
  localparam logic [7:0] OFF_STATUS = 8'h1c;
  localparam logic [7:0] OFF_VECTOR = 8'h20;
  // ****************************************
  // status word layout
  // ****************************************
  localparam int BIT_CF = 0;
  localparam int BIT_PF = 2;
  localparam int BIT_AF = 4;
  localparam int BIT_ZF = 6;
  localparam int BIT_SF = 7;
  localparam int BIT_TF = 8;
  localparam int BIT_IF = 9;
  localparam int BIT_DF = 10;
  localparam int BIT_OF = 11;
  localparam logic [15:0] PSW_DEFINED = 16'h0fd5;
  localparam logic [15:0] PSW_FIXED = 16'h0000;
  localparam logic [15:0] PSW_RST = 16'h0000;
  // ****************************************
  // command word fields
  // ****************************************
  localparam int CMD_W = 19;
  localparam int CMD_OP = 0;
  localparam int CMD_WORD = 4;
  localparam int CMD_NOPD = 5;
  localparam int CMD_SRC = 7;
  localparam int CMD_DST = 9;
  localparam int CMD_GRP = 11;
  localparam int CMD_REP = 14;
  localparam int CMD_STR = 16;
  localparam int CMD_LEN = 17;
  localparam logic [2:0] GRP_ILLEGAL = 3'h7;
  localparam logic [1:0] NOPD_ILLEGAL = 2'h3;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;
  typedef enum logic [3:0] {
    OP_ADD = 4'h0, OP_ADC = 4'h1, OP_SUB = 4'h2, OP_SBB = 4'h3,
    OP_AND = 4'h4, OP_OR = 4'h5, OP_XOR = 4'h6, OP_RCL = 4'h7,
    OP_RCR = 4'h8, OP_INC = 4'h9, OP_DEC = 4'ha, OP_CMP = 4'hb
  } fad_op_t;
  typedef enum logic [1:0] {
    REP_NONE = 2'h0, REP_ALL = 2'h1, REP_EQ = 2'h2, REP_NE = 2'h3
  } fad_rep_t;
  typedef enum logic [1:0] {
    K_REG = 2'h0, K_IMM = 2'h1, K_MEM = 2'h2, K_BAD = 2'h3
  } fad_kind_t;
endpackage

/* File: hw/fad_top.sv */
// Purpose: result path and status word of a 16-bit core, axi4-lite slave
// Assumes: one clock, registers reached only over the bus
// Notes: unknown op codes are legal and change no status bit but the step flag, which clears
// What this block does
// - carry set on msb carry or borrow
// - parity set on even ones, low byte
// - half carry from low four bits
// - zero set when result is zero
// - sign copies result msb
// - overflow on signed range overflow
// - step flag traps after next instruction
// - trap service clears step flag
// - interrupt enable gates maskable requests
// - direction set makes strings decrement
// - direction clear makes strings increment
// - zero, one or two operands
// - six two-operand transfer forms
// - memory-memory only for string class
// - seven instruction groups
// - carry feeds add and subtract with borrow
// - carry joins rotate through carry chain
// - conditional repeat follows zero flag
// - status word is sixteen bits
//
// The address map and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module fad_top
  import fad_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic irq_req,
  output logic irq_ack,
  output logic [7:0] irq_vector,
  output logic step_trap
);
  // decode reads address bits 7 to 2
  if (ADDR_W < 8) begin : g_chk
    $error("ADDR_W must be at least 8");
  end
  // ****************************************
  // reset release
  // ****************************************
  logic rst_m, rst_q;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_m <= 1'b0;
      rst_q <= 1'b0;
    end else begin
      rst_m <= 1'b1;
      rst_q <= rst_m;
    end
  end
  function automatic logic [31:0] wmerge(input logic [31:0] old,
                                         input logic [31:0] d, input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) r[8*i +: 8] = d[8*i +: 8];
    end
    return r;
  endfunction
  // ****************************************
  // axi4-lite write channel
  // ****************************************
  logic awready_q, wready_q, bvalid_q, aw_have_q, w_have_q;
  logic [1:0] bresp_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic wr_fire, wr_ok;
  assign wr_fire = aw_have_q && w_have_q && !bvalid_q;
  assign wr_ok = (awaddr_q == OFF_OPA) || (awaddr_q == OFF_OPB) ||
                 (awaddr_q == OFF_CMD) || (awaddr_q == OFF_PSW) ||
                 (awaddr_q == OFF_INDEX) || (awaddr_q == OFF_COUNT) ||
                 (awaddr_q == OFF_STATUS) || (awaddr_q == OFF_VECTOR);
  always_ff @(posedge clk_sys or negedge rst_q) begin
    if (!rst_q) begin
      awready_q <= 1'b0;
      aw_have_q <= 1'b0;
      awaddr_q <= 8'h00;
    end else if (awready_q && s_axi_awvalid) begin
      awready_q <= 1'b0;
      aw_have_q <= 1'b1;
      awaddr_q <= {s_axi_awaddr[7:2], 2'b00};
    end else if (wr_fire) begin
      aw_have_q <= 1'b0;
    end else if (!aw_have_q && !bvalid_q) begin
      awready_q <= 1'b1;
    end
  end
  always_ff @(posedge clk_sys or negedge rst_q) begin
    if (!rst_q) begin
      wready_q <= 1'b0;
      w_have_q <= 1'b0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else if (wready_q && s_axi_wvalid) begin
      wready_q <= 1'b0;
      w_have_q <= 1'b1;
      wdata_q <= s_axi_wdata;
      wstrb_q <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_have_q <= 1'b0;
    end else if (!w_have_q && !bvalid_q) begin
      wready_q <= 1'b1;
    end
  end
  always_ff @(posedge clk_sys or negedge rst_q) begin
    if (!rst_q) begin
      bvalid_q <= 1'b0;
      bresp_q <= AXI_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_ok ? AXI_OKAY : AXI_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end
  logic wsel_opa, wsel_opb, wsel_cmd, wsel_psw, wsel_idx, wsel_cnt, wsel_st, wsel_vec;
  assign wsel_opa = wr_fire && (awaddr_q == OFF_OPA);
  assign wsel_opb = wr_fire && (awaddr_q == OFF_OPB);
  assign wsel_cmd = wr_fire && (awaddr_q == OFF_CMD);
  assign wsel_psw = wr_fire && (awaddr_q == OFF_PSW);
  assign wsel_idx = wr_fire && (awaddr_q == OFF_INDEX);
  assign wsel_cnt = wr_fire && (awaddr_q == OFF_COUNT);
  assign wsel_st = wr_fire && (awaddr_q == OFF_STATUS);
  assign wsel_vec = wr_fire && (awaddr_q == OFF_VECTOR);
  // ****************************************
  // operand, command and result registers
  // ****************************************
  logic [15:0] opa_q, opb_q, res_q, psw_q, idx_q, cnt_q;
  logic [CMD_W-1:0] cmd_q;
  logic [7:0] vec_q;
  logic cmd_wr_q, run_q, err_q;
  logic [31:0] m_opa, m_opb, m_cmd, m_psw, m_idx, m_cnt, m_vec;
  assign m_opa = wmerge({16'h0000, opa_q}, wdata_q, wstrb_q);
  assign m_opb = wmerge({16'h0000, opb_q}, wdata_q, wstrb_q);
  assign m_cmd = wmerge({13'h0000, cmd_q}, wdata_q, wstrb_q);
  assign m_psw = wmerge({16'h0000, psw_q}, wdata_q, wstrb_q);
  assign m_idx = wmerge({16'h0000, idx_q}, wdata_q, wstrb_q);
  assign m_cnt = wmerge({16'h0000, cnt_q}, wdata_q, wstrb_q);
  assign m_vec = wmerge({24'h000000, vec_q}, wdata_q, wstrb_q);
  always_ff @(posedge clk_sys or negedge rst_q) begin
    if (!rst_q) begin
      opa_q <= 16'h0000;
      opb_q <= 16'h0000;
      cmd_q <= '0;
      vec_q <= 8'h00;
      cmd_wr_q <= 1'b0;
    end else begin
      if (wsel_opa) opa_q <= m_opa[15:0];
      if (wsel_opb) opb_q <= m_opb[15:0];
      if (wsel_cmd) cmd_q <= m_cmd[CMD_W-1:0];
      if (wsel_vec) vec_q <= m_vec[7:0];
      cmd_wr_q <= wsel_cmd;
    end
  end
  // ****************************************
  // command decode and legality
  // ****************************************
  fad_op_t op;
  fad_rep_t rep;
  fad_kind_t src, dst;
  logic word, strg, legal, exec, rep_skip, do_elem;
  logic [1:0] nopd, len;
  logic [2:0] grp;
  assign op = fad_op_t'(cmd_q[CMD_OP +: 4]);
  assign word = cmd_q[CMD_WORD];
  assign nopd = cmd_q[CMD_NOPD +: 2];
  assign src = fad_kind_t'(cmd_q[CMD_SRC +: 2]);
  assign dst = fad_kind_t'(cmd_q[CMD_DST +: 2]);
  assign grp = cmd_q[CMD_GRP +: 3];
  assign rep = fad_rep_t'(cmd_q[CMD_REP +: 2]);
  assign strg = cmd_q[CMD_STR];
  assign len = cmd_q[CMD_LEN +: 2];
  assign legal = (nopd != NOPD_ILLEGAL) && (grp != GRP_ILLEGAL) &&
                 (src != K_BAD) && (dst != K_BAD) && (dst != K_IMM) &&
                 !(nopd == 2'h2 && src == K_MEM && dst == K_MEM && !strg) &&
                 (!strg || len != 2'h0);
  assign exec = cmd_wr_q || run_q;
  assign rep_skip = strg && (rep != REP_NONE) && (cnt_q == 16'h0000);
  assign do_elem = exec && legal && !rep_skip;
  // ****************************************
  // arithmetic and logic
  // ****************************************
  logic [15:0] am, bm, bv, ares, res_n, hx;
  logic [16:0] ext;
  logic cf, cin, sub, acf, sa, sb, sr, aof;
  logic cf_n, af_n, of_n, arith, rot, wr_res, zf_n, sf_n, pf_n;
  assign cf = psw_q[BIT_CF];
  assign am = word ? opa_q : {8'h00, opa_q[7:0]};
  assign bm = word ? opb_q : {8'h00, opb_q[7:0]};
  assign bv = (op == OP_INC || op == OP_DEC) ? 16'h0001 : bm;
  assign cin = (op == OP_ADC || op == OP_SBB) && cf;
  assign sub = (op == OP_SUB) || (op == OP_SBB) || (op == OP_DEC) || (op == OP_CMP);
  assign ext = sub ? ({1'b0, am} - {1'b0, bv} - {16'h0000, cin}) :
                     ({1'b0, am} + {1'b0, bv} + {16'h0000, cin});
  assign ares = word ? ext[15:0] : {8'h00, ext[7:0]};
  assign acf = word ? ext[16] : ext[8];
  assign hx = am ^ bv ^ ares;
  assign sa = word ? am[15] : am[7];
  assign sb = word ? bv[15] : bv[7];
  assign sr = word ? ares[15] : ares[7];
  assign aof = sub ? ((sa != sb) && (sr != sa)) : ((sa == sb) && (sr != sa));
  always_comb begin
    res_n = ares;
    cf_n = acf;
    af_n = hx[4];
    of_n = aof;
    arith = 1'b1;
    rot = 1'b0;
    wr_res = 1'b1;
    case (op)
      OP_ADD, OP_ADC, OP_SUB, OP_SBB: begin
        arith = 1'b1;
      end
      OP_INC, OP_DEC: begin
        cf_n = cf;
      end
      OP_CMP: begin
        wr_res = 1'b0;
      end
      OP_AND, OP_OR, OP_XOR: begin
        arith = 1'b0;
        res_n = (op == OP_AND) ? (am & bm) : (op == OP_OR) ? (am | bm) : (am ^ bm);
        cf_n = 1'b0;
        of_n = 1'b0;
        af_n = psw_q[BIT_AF];
      end
      OP_RCL: begin
        rot = 1'b1;
        res_n = word ? {am[14:0], cf} : {8'h00, am[6:0], cf};
        cf_n = word ? am[15] : am[7];
        of_n = (word ? am[14] : am[6]) ^ cf_n;
      end
      OP_RCR: begin
        rot = 1'b1;
        res_n = word ? {cf, am[15:1]} : {8'h00, cf, am[7:1]};
        cf_n = am[0];
        of_n = cf ^ (word ? am[15] : am[7]);
      end
      default: begin
        // unknown codes keep every status bit except the step flag, which clears
        rot = 1'b1;
        wr_res = 1'b0;
        arith = 1'b0;
        res_n = res_q;
        cf_n = cf;
        af_n = psw_q[BIT_AF];
        of_n = psw_q[BIT_OF];
      end
    endcase
  end
  assign zf_n = word ? (res_n == 16'h0000) : (res_n[7:0] == 8'h00);
  assign sf_n = word ? res_n[15] : res_n[7];
  assign pf_n = ~^res_n[7:0];
  // ****************************************
  // status word and result update
  // ****************************************
  logic [15:0] psw_n;
  always_comb begin
    psw_n = psw_q;
    psw_n[BIT_CF] = cf_n;
    psw_n[BIT_OF] = of_n;
    if (!rot) begin
      psw_n[BIT_ZF] = zf_n;
      psw_n[BIT_SF] = sf_n;
      psw_n[BIT_PF] = pf_n;
      psw_n[BIT_AF] = arith ? af_n : psw_q[BIT_AF];
    end
    psw_n[BIT_TF] = 1'b0;
  end
  always_ff @(posedge clk_sys or negedge rst_q) begin
    if (!rst_q) begin
      psw_q <= PSW_RST;
      res_q <= 16'h0000;
    end else if (do_elem) begin
      psw_q <= (psw_n & PSW_DEFINED) | PSW_FIXED;
      if (wr_res) res_q <= res_n;
    end else if (wsel_psw) begin
      psw_q <= (m_psw[15:0] & PSW_DEFINED) | PSW_FIXED;
    end
  end
  // ****************************************
  // string index, repeat count, errors
  // ****************************************
  logic [15:0] step;
  logic rep_go;
  assign step = word ? 16'h0002 : 16'h0001;
  assign rep_go = (rep == REP_ALL) || (rep == REP_EQ && zf_n) || (rep == REP_NE && !zf_n);
  always_ff @(posedge clk_sys or negedge rst_q) begin
    if (!rst_q) begin
      idx_q <= 16'h0000;
    end else if (do_elem && strg) begin
      idx_q <= psw_q[BIT_DF] ? (idx_q - step) : (idx_q + step);
    end else if (wsel_idx) begin
      idx_q <= m_idx[15:0];
    end
  end
  always_ff @(posedge clk_sys or negedge rst_q) begin
    if (!rst_q) begin
      cnt_q <= 16'h0000;
      run_q <= 1'b0;
    end else begin
      run_q <= do_elem && strg && (rep != REP_NONE) && (cnt_q != 16'h0001) && rep_go;
      if (do_elem && strg && rep != REP_NONE) cnt_q <= cnt_q - 16'h0001;
      else if (wsel_cnt) cnt_q <= m_cnt[15:0];
    end
  end
  // a new error wins over a same-cycle clear
  always_ff @(posedge clk_sys or negedge rst_q) begin
    if (!rst_q) err_q <= 1'b0;
    else if (exec && !legal) err_q <= 1'b1;
    else if (wsel_st && wstrb_q[0] && wdata_q[0]) err_q <= 1'b0;
  end
  // ****************************************
  // step trap and maskable interrupt
  // ****************************************
  logic irq_m, irq_s, irq_p, trap_q, ack_q;
  logic [7:0] ivec_q;
  always_ff @(posedge clk_sys or negedge rst_q) begin
    if (!rst_q) begin
      irq_m <= 1'b0;
      irq_s <= 1'b0;
      irq_p <= 1'b0;
      trap_q <= 1'b0;
      ack_q <= 1'b0;
      ivec_q <= 8'h00;
    end else begin
      irq_m <= irq_req;
      irq_s <= irq_m;
      irq_p <= irq_s;
      trap_q <= do_elem && psw_q[BIT_TF];
      ack_q <= irq_s && !irq_p && psw_q[BIT_IF];
      if (irq_s && !irq_p && psw_q[BIT_IF]) ivec_q <= vec_q;
    end
  end
  // ****************************************
  // axi4-lite read channel
  // ****************************************
  logic arready_q, rvalid_q;
  logic [31:0] rdata_q, rd_mux;
  logic [1:0] rresp_q;
  logic rd_ok;
  always_comb begin
    rd_ok = 1'b1;
    case ({s_axi_araddr[7:2], 2'b00})
      OFF_OPA: rd_mux = {16'h0000, opa_q};
      OFF_OPB: rd_mux = {16'h0000, opb_q};
      OFF_CMD: rd_mux = {13'h0000, cmd_q};
      OFF_RESULT: rd_mux = {16'h0000, res_q};
      OFF_PSW: rd_mux = {16'h0000, psw_q};
      OFF_INDEX: rd_mux = {16'h0000, idx_q};
      OFF_COUNT: rd_mux = {16'h0000, cnt_q};
      OFF_STATUS: rd_mux = {30'h00000000, exec, err_q};
      OFF_VECTOR: rd_mux = {24'h000000, vec_q};
      default: begin
        rd_mux = 32'h0000_0000;
        rd_ok = 1'b0;
      end
    endcase
  end
  always_ff @(posedge clk_sys or negedge rst_q) begin
    if (!rst_q) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= AXI_OKAY;
    end else if (arready_q && s_axi_arvalid) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= rd_mux;
      rresp_q <= rd_ok ? AXI_OKAY : AXI_SLVERR;
    end else if (rvalid_q) begin
      if (s_axi_rready) rvalid_q <= 1'b0;
    end else begin
      arready_q <= 1'b1;
    end
  end
  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign irq_ack = ack_q;
  assign irq_vector = ivec_q;
  assign step_trap = trap_q;
  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_q);
  logic [16:0] chk_sum;
  logic [4:0] chk_lo;
  logic add_w, add_b;
  assign chk_sum = {1'b0, opa_q} + {1'b0, opb_q};
  assign chk_lo = {1'b0, opa_q[3:0]} + {1'b0, opb_q[3:0]};
  assign add_w = do_elem && op == OP_ADD && word;
  assign add_b = do_elem && op == OP_ADD && !word;
  sequence seq_step_exec;
    do_elem && psw_q[BIT_TF];
  endsequence
  sequence seq_trap_taken;
    trap_q && !psw_q[BIT_TF];
  endsequence
  AST_CARRY: assert property (add_w |=> psw_q[BIT_CF] == $past(chk_sum[16]))
    else $error("carry flag wrong after add");
  AST_PARITY: assert property (add_w |=> psw_q[BIT_PF] == ~^res_q[7:0])
    else $error("parity flag does not match result");
  AST_HALF: assert property (add_b |=> psw_q[BIT_AF] == $past(chk_lo[4]))
    else $error("half carry wrong after byte add");
  AST_ZERO: assert property (add_w |=> psw_q[BIT_ZF] == (res_q == 16'h0000))
    else $error("zero flag does not match result");
  AST_SIGN: assert property (add_w |=> psw_q[BIT_SF] == res_q[15])
    else $error("sign flag does not match result msb");
  AST_OVF: assert property (add_w |=> psw_q[BIT_OF] ==
    $past(opa_q[15] == opb_q[15] && chk_sum[15] != opa_q[15]))
    else $error("overflow flag wrong after add");
  AST_STEP: assert property (seq_step_exec |=> seq_trap_taken)
    else $error("step trap missing or step flag kept");
  AST_NOSTEP: assert property (trap_q |-> $past(psw_q[BIT_TF]) && !psw_q[BIT_TF])
    else $error("trap without step flag");
  AST_IRQ: assert property (ack_q |-> $past(psw_q[BIT_IF]) && ivec_q == $past(vec_q))
    else $error("interrupt accepted while disabled");
  AST_DEC: assert property (do_elem && strg && psw_q[BIT_DF]
    |=> idx_q == $past(idx_q) - ($past(word) ? 16'h0002 : 16'h0001))
    else $error("string index did not decrement");
  AST_INC: assert property (do_elem && strg && !psw_q[BIT_DF] && word
    |=> idx_q == $past(idx_q) + 16'h0002)
    else $error("string index did not increment");
  AST_MEMMEM: assert property (exec && nopd == 2'h2 && src == K_MEM && dst == K_MEM
    && !strg |=> err_q && $stable(res_q))
    else $error("memory pair accepted outside string class");
  AST_GRP: assert property (exec && grp == GRP_ILLEGAL |=> err_q)
    else $error("illegal group not flagged");
  AST_ADC: assert property (do_elem && op == OP_ADC && word
    |=> res_q == $past(opa_q + opb_q + {15'h0000, cf}))
    else $error("add with carry ignored carry");
  AST_RCL: assert property (do_elem && op == OP_RCL && word
    |=> res_q == {$past(opa_q[14:0]), $past(cf)} && psw_q[BIT_CF] == $past(opa_q[15]))
    else $error("rotate through carry wrong");
  AST_REPSTOP: assert property (do_elem && strg && rep == REP_EQ && !zf_n |=> !run_q)
    else $error("repeat kept going after mismatch");
  AST_RSVD: assert property ((psw_q & ~PSW_DEFINED) == PSW_FIXED)
    else $error("unassigned status bits changed");
endmodule
`default_nettype wire

/* File: verification/flag_alu_datapath_tb.sv */
// Purpose: self-checking bench for the flag alu datapath
// Assumes: axi4-lite master, inputs change right after the rising edge
// Notes: outputs are sampled at the falling edge, where every flop has settled
`timescale 1ns/100ps
`default_nettype none
module flag_alu_datapath_tb;
  import fad_pkg::*;
  logic clk_sys, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic irq_req, irq_ack, step_trap;
  logic [7:0] s_axi_awaddr, s_axi_araddr, irq_vector;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  int bad_count, comparisons, n_step, n_ack, k;
  fad_top uut (.clk_sys, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .irq_req, .irq_ack, .irq_vector, .step_trap);
  // ****************************************
  // bus tasks and checks
  // ****************************************
  task automatic test_done();
    if (bad_count == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("Error %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // one access; ready sampled at the falling edge equals its value at the next rising edge
  task automatic xfer(input bit wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    bit pend, ha, hw, hr;
    pend = 1;
    n = 0;
    @(posedge clk_sys);
    if (wr) begin
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
    end else begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
    end
    while (pend && n < 60) begin
      @(negedge clk_sys);
      n++;
      ha = s_axi_awvalid & s_axi_awready;
      hw = s_axi_wvalid & s_axi_wready;
      hr = s_axi_arvalid & s_axi_arready;
      if (wr && s_axi_bvalid === 1'b1) begin
        rs = s_axi_bresp;
        pend = 0;
      end
      if (!wr && s_axi_rvalid === 1'b1) begin
        rs = s_axi_rresp;
        rd = s_axi_rdata;
        pend = 0;
      end
      @(posedge clk_sys);
      if (ha) s_axi_awvalid <= 1'b0;
      if (hw) s_axi_wvalid <= 1'b0;
      if (hr) s_axi_arvalid <= 1'b0;
      if (!pend) s_axi_bready <= 1'b0;
      if (!pend) s_axi_rready <= 1'b0;
    end
    if (pend) begin
      bad_count++;
      $display("Error %0t: bus timeout", $time);
      test_done();
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic alu(input logic [3:0] op, input bit w, input logic [1:0] nopd,
    input logic [15:0] a, input logic [15:0] b, input logic [15:0] er, input logic [15:0] ep);
    logic [2:0] grp;
    grp = (op == OP_RCL || op == OP_RCR) ? 3'h2 : 3'h1;
    xfer(1'b1, OFF_OPA, {16'h0, a});
    xfer(1'b1, OFF_OPB, {16'h0, b});
    xfer(1'b1, OFF_CMD, {13'h0, 2'h1, 3'h0, grp, 4'h0, nopd, w, op});
    rdchk(OFF_RESULT, {16'h0, er});
    rdchk(OFF_PSW, {16'h0, ep});
  endtask
  // counted repeated string; str clear turns the same mem-mem form illegal
  task automatic strop(input logic [15:0] psw, input bit str, input logic [1:0] rp,
    input logic [31:0] ei);
    xfer(1'b1, OFF_PSW, {16'h0, psw});
    xfer(1'b1, OFF_INDEX, 32'h100);
    xfer(1'b1, OFF_COUNT, 32'h3);
    xfer(1'b1, OFF_CMD, {13'h0, 2'h1, str, rp, 3'h3, 2'h2, 2'h2, 2'h2, 1'b1, 4'h0});
    k = 0;
    rd = 32'h2;
    while (rd[1] !== 1'b0 && k < 20) begin
      xfer(1'b0, OFF_STATUS, 32'h0);
      k++;
    end
    if (rd[1] !== 1'b0) begin
      bad_count++;
      $display("Error %0t: busy never cleared", $time);
      test_done();
    end
    rdchk(OFF_INDEX, ei);
  endtask
  task automatic pulse_irq();
    @(posedge clk_sys);
    irq_req <= 1'b1;
    repeat (6) @(posedge clk_sys);
    irq_req <= 1'b0;
    repeat (6) @(posedge clk_sys);
  endtask
  always @(negedge clk_sys) begin
    if (step_trap === 1'b1) n_step++;
    if (irq_ack === 1'b1) n_ack++;
  end
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, irq_req} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rdchk(OFF_PSW, 32'h0);
    xfer(1'b1, OFF_PSW, 32'hffff_ffff);
    rdchk(OFF_PSW, 32'h0fd5);
    xfer(1'b1, OFF_PSW, 32'h0);
    chk(rs, AXI_OKAY);
    xfer(1'b0, 8'h40, 32'h0);
    chk(rs, AXI_SLVERR);
    xfer(1'b1, OFF_RESULT, 32'h1);
    chk(rs, AXI_SLVERR);
    alu(OP_ADD, 1, 2, 16'h7fff, 16'h0001, 16'h8000, 16'h0894);
    alu(OP_ADD, 0, 2, 16'h00ff, 16'h0001, 16'h0000, 16'h0055);
    alu(OP_INC, 1, 1, 16'h7fff, 16'h0000, 16'h8000, 16'h0895);
    alu(OP_ADC, 1, 2, 16'h0001, 16'h0001, 16'h0003, 16'h0004);
    alu(OP_SUB, 1, 2, 16'h0000, 16'h0001, 16'hffff, 16'h0095);
    alu(OP_SBB, 1, 2, 16'h0005, 16'h0002, 16'h0002, 16'h0000);
    alu(OP_DEC, 0, 1, 16'h0000, 16'h0000, 16'h00ff, 16'h0094);
    alu(4'hc, 1, 2, 16'h1234, 16'h0001, 16'h00ff, 16'h0094);
    alu(OP_RCL, 0, 1, 16'h0080, 16'h0000, 16'h0000, 16'h0895);
    alu(OP_RCR, 0, 1, 16'h0001, 16'h0000, 16'h0080, 16'h0895);
    alu(OP_RCL, 1, 1, 16'h8001, 16'h0000, 16'h0003, 16'h0895);
    alu(OP_AND, 1, 2, 16'h0ff0, 16'h0f0f, 16'h0f00, 16'h0014);
    alu(OP_CMP, 1, 2, 16'h0005, 16'h0005, 16'h0f00, 16'h0044);
    alu(OP_OR, 0, 2, 16'h0080, 16'h0001, 16'h0081, 16'h0084);
    alu(OP_XOR, 1, 2, 16'hffff, 16'hffff, 16'h0000, 16'h0044);
    xfer(1'b1, OFF_PSW, 32'h0100);
    n_step = 0;
    alu(OP_ADD, 1, 2, 16'h0001, 16'h0001, 16'h0002, 16'h0000);
    chk(n_step, 1);
    xfer(1'b1, OFF_VECTOR, 32'h5a);
    n_ack = 0;
    pulse_irq();
    chk(n_ack, 0);
    xfer(1'b1, OFF_PSW, 32'h0200);
    pulse_irq();
    chk(n_ack, 1);
    chk(irq_vector, 8'h5a);
    strop(16'h0000, 1'b1, 2'h1, 32'h106);
    strop(16'h0400, 1'b1, 2'h1, 32'h0fa);
    strop(16'h0000, 1'b1, 2'h2, 32'h102);
    strop(16'h0000, 1'b1, 2'h3, 32'h106);
    rdchk(OFF_STATUS, 32'h0);
    strop(16'h0000, 1'b0, 2'h1, 32'h100);
    rdchk(OFF_STATUS, 32'h1);
    xfer(1'b1, OFF_STATUS, 32'h1);
    rdchk(OFF_STATUS, 32'h0);
    xfer(1'b1, OFF_CMD, 32'h0000_3800);
    rdchk(OFF_STATUS, 32'h1);
    test_done();
  end
endmodule
`default_nettype wire
